// file: hdl/cgfm_top.sv
// character generator and field modifier video: display memory to serial dots
// assumes one 10 MHz dot clock, a processor on the same clock, and a glyph table loaded by the user
// How it works
// - glyph dots load then shift out serially
// - glyph table 2K by 8, bit 7 ignored
// - scan counter drives four low glyph address bits
// - seven-bit code drives seven high address bits
// - fetch pairs, present singly on internal bus
// - bit 7 set: latch word as attributes
// - bit 7 clear: bits 6..0 are code
// - bits 5..2 underscore inverse dim blink
// - blink attribute ANDs video with oscillator
// - underscore forces video on scan twelve
// - inverse inverts video except during retrace
// - dim attribute drives dim output
// - modifier cell shows two-bar dot pattern
// - even and odd banks read together
// - 2048 locations, 1920 screen, 128 spare
// - refresh owns phase 1, processor phase 2
// - scan counter counts modulo twelve
// - dot counter divides by ten
`timescale 1ns/10ps
`default_nettype none
`include "cgfm_consts.svh"
module cgfm_top #(
	parameter logic [7:0] BLINK_FRAMES = `CGFM_BLINK_FRAMES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [10:0] topOfPage,
	input wire logic cpuReq,
	input wire logic cpuWe,
	input wire logic [10:0] cpuAddr,
	input wire logic [7:0] cpuWrData,
	output logic cpuAck,
	output logic [7:0] cpuRdData,
	input wire logic glyphWe,
	input wire logic [10:0] glyphAddr,
	input wire logic [7:0] glyphWrData,
	output logic video,
	output logic dimOut,
	output logic hDrive,
	output logic vSync
);
	// refresh counters
	logic [3:0] dotCnt_reg; // dot within cell
	logic [6:0] charCnt_reg; // cell within scan line
	logic [3:0] scanCnt_reg; // scan within character row
	logic [8:0] lineCnt_reg; // scan line within frame
	logic [10:0] rowBase_reg; // first location of the current row
	logic lineEnd; // last dot of a scan line
	logic frameEnd; // last dot of a frame
	logic frameStart; // first dot of a frame
	logic phase2; // processor half of each cell
	logic [10:0] colAddr; // location of the current cell
	// fetch and bus stages
	logic fetch; // refresh reads a pair this cycle
	logic fetchD_reg; // pair data valid at the banks
	cgfm_pkg::cgfm_char_t holdEven_reg; // holding buffer, even bank
	cgfm_pkg::cgfm_char_t holdOdd_reg; // holding buffer, odd bank
	cgfm_pkg::cgfm_char_t charBus_reg; // internal character bus
	logic busVis_reg; // bus word belongs to the visible screen
	logic busStrobe; // new word on the bus this cycle
	cgfm_pkg::cgfm_attr_t attr_reg; // attribute latch
	// cell stage, aligned with the shift register
	cgfm_pkg::cgfm_attr_t cellAttr_reg; // attributes of the cell going out
	logic cellMod_reg; // cell is a field modifier
	logic cellVis_reg; // cell is outside retrace
	logic cellScan12_reg; // cell is on the underscore scan
	logic loadCell; // shift register load slot
	logic shiftDot; // dot leaving the shift register
	logic barDot; // two-bar pattern dot
	logic dotNext; // video before the output register
	// processor port
	logic cpuTake; // request taken this cycle
	logic cpuPend_reg; // read data arrive next cycle
	logic cpuSel_reg; // bank of the pending access
	logic cpuAck_reg;
	logic [7:0] cpuRdData_reg;
	// outputs and blink oscillator
	logic video_reg;
	logic dim_reg;
	logic hDrive_reg;
	logic vSync_reg;
	logic [7:0] frameCnt_reg; // frames since last blink toggle
	logic blinkOsc_reg; // blink oscillator
	// memory ports
	cgfm_mem_if #(.AW(10), .DW(8)) evenBus();
	cgfm_mem_if #(.AW(10), .DW(8)) oddBus();
	cgfm_mem_if #(.AW(11), .DW(8)) glyphBus();

	assign lineEnd = (dotCnt_reg == `CGFM_DOT_LAST) && (charCnt_reg == `CGFM_CHAR_LAST);
	assign frameEnd = lineEnd && (lineCnt_reg == `CGFM_LINE_LAST);
	assign frameStart = (dotCnt_reg == 4'h0) && (charCnt_reg == 7'h00) && (lineCnt_reg == 9'h000);
	assign phase2 = (dotCnt_reg >= `CGFM_PHASE2_DOT);

	// dot counter, divide by ten
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dotCnt_reg <= 4'h0;
		end else if (dotCnt_reg == `CGFM_DOT_LAST) begin
			dotCnt_reg <= 4'h0;
		end else begin
			dotCnt_reg <= dotCnt_reg + 4'h1;
		end
	end

	// character counter, one hundred cells per scan line
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			charCnt_reg <= 7'h00;
		end else if (dotCnt_reg == `CGFM_DOT_LAST) begin
			charCnt_reg <= (charCnt_reg == `CGFM_CHAR_LAST) ? 7'h00 : charCnt_reg + 7'h01;
		end
	end

	// scan counter modulo twelve, restarted each frame so rows stay aligned
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			scanCnt_reg <= 4'h0;
		end else if (frameEnd) begin
			scanCnt_reg <= 4'h0;
		end else if (lineEnd) begin
			scanCnt_reg <= (scanCnt_reg == `CGFM_SCAN_LAST) ? 4'h0 : scanCnt_reg + 4'h1;
		end
	end

	// line counter over the whole frame
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lineCnt_reg <= 9'h000;
		end else if (lineEnd) begin
			lineCnt_reg <= frameEnd ? 9'h000 : lineCnt_reg + 9'h001;
		end
	end

	// row base: top of page at frame end, one row further after each twelfth scan
	// the 11-bit sum wraps at 2048, which returns the counters to the start of memory
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rowBase_reg <= 11'h000;
		end else if (frameEnd) begin
			rowBase_reg <= topOfPage;
		end else if (lineEnd && (scanCnt_reg == `CGFM_SCAN_LAST)) begin
			rowBase_reg <= rowBase_reg + `CGFM_ROW_STEP;
		end
	end

	assign colAddr = rowBase_reg + {4'h0, charCnt_reg};
	// a pair is read at the first dot of every even visible cell
	assign fetch = (dotCnt_reg == `CGFM_FETCH_DOT) && !charCnt_reg[0] && (charCnt_reg < `CGFM_VIS_COLS);
	// the processor waits for phase 2; it holds cpuReq until acknowledged
	assign cpuTake = cpuReq && (dotCnt_reg == `CGFM_CPU_DOT) && !cpuPend_reg && !cpuAck_reg;

	// bank address mux: refresh in phase 1, processor in phase 2
	always_comb begin
		evenBus.addr = phase2 ? cpuAddr[10:1] : colAddr[10:1];
		oddBus.addr = phase2 ? cpuAddr[10:1] : colAddr[10:1];
		evenBus.we = cpuTake && cpuWe && !cpuAddr[0];
		oddBus.we = cpuTake && cpuWe && cpuAddr[0];
		evenBus.wdata = cpuWrData;
		oddBus.wdata = cpuWrData;
	end

	// two 1K banks give the 2048 locations; with topOfPage zero the top 128 are never displayed
	cgfm_mem #(.AW(10), .DW(8)) u_even (.clock(clock), .port(evenBus.mem));
	cgfm_mem #(.AW(10), .DW(8)) u_odd (.clock(clock), .port(oddBus.mem));

	// holding buffer takes both banks one cycle after the pair read
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fetchD_reg <= 1'b0;
			holdEven_reg <= 8'h00;
			holdOdd_reg <= 8'h00;
		end else begin
			fetchD_reg <= fetch;
			if (fetchD_reg) begin
				holdEven_reg <= evenBus.rdata;
				holdOdd_reg <= oddBus.rdata;
			end
		end
	end

	assign busStrobe = (dotCnt_reg == `CGFM_BUS_DOT);
	// one word of the pair per cell onto the internal bus
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			charBus_reg <= 8'h00;
			busVis_reg <= 1'b0;
		end else if (busStrobe) begin
			charBus_reg <= charCnt_reg[0] ? holdOdd_reg : holdEven_reg;
			busVis_reg <= (charCnt_reg < `CGFM_VIS_COLS) && (lineCnt_reg < `CGFM_VIS_LINES);
		end
	end

	// attribute latch: modifier words land here, reserved bits dropped
	// frame start and capture never share a cycle, so no capture is lost
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			attr_reg <= '0;
		end else if (frameStart) begin
			attr_reg <= '0;
		end else if ((dotCnt_reg == `CGFM_ATTR_DOT) && busVis_reg && charBus_reg[`CGFM_FM_BIT]) begin
			attr_reg.underscore <= charBus_reg[`CGFM_UL_BIT];
			attr_reg.inverse <= charBus_reg[`CGFM_INV_BIT];
			attr_reg.dim <= charBus_reg[`CGFM_DIM_BIT];
			attr_reg.blink <= charBus_reg[`CGFM_BLK_BIT];
		end
	end

	// glyph address: code bits 6..0 high, scan low; a load from the user takes the port
	always_comb begin
		glyphBus.addr = glyphWe ? glyphAddr : {charBus_reg[6:0], scanCnt_reg};
		glyphBus.we = glyphWe;
		glyphBus.wdata = glyphWrData;
	end

	cgfm_mem #(.AW(11), .DW(8)) u_glyph (.clock(clock), .port(glyphBus.mem));

	assign loadCell = (dotCnt_reg == `CGFM_LOAD_DOT);
	// seven dots then three blank separation dots; glyph bit 7 never reaches the screen
	cgfm_shift #(.W(10)) u_shift (
		.clock(clock),
		.rst_n(rst_n),
		.load(loadCell),
		.din({glyphBus.rdata[6:0], 3'h0}),
		.dout(shiftDot)
	);

	// cell stage: attributes and flags travel with the glyph into the shifter
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cellAttr_reg <= '0;
			cellMod_reg <= 1'b0;
			cellVis_reg <= 1'b0;
			cellScan12_reg <= 1'b0;
		end else if (loadCell) begin
			cellAttr_reg <= attr_reg;
			cellMod_reg <= busVis_reg && charBus_reg[`CGFM_FM_BIT];
			cellVis_reg <= busVis_reg;
			cellScan12_reg <= (scanCnt_reg == `CGFM_UL_SCAN);
		end
	end

	assign barDot = (dotCnt_reg == `CGFM_BAR_A) || (dotCnt_reg == `CGFM_BAR_B);
	// video chain: glyph or bars, underscore, blink, inverse, then blanking last
	always_comb begin
		dotNext = cellMod_reg ? barDot : shiftDot;
		if (cellAttr_reg.underscore && cellScan12_reg) begin
			dotNext = 1'b1;
		end
		if (cellAttr_reg.blink) begin
			dotNext = dotNext & blinkOsc_reg;
		end
		if (cellAttr_reg.inverse) begin
			dotNext = ~dotNext;
		end
		if (!cellVis_reg) begin
			dotNext = 1'b0;
		end
	end

	// output registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			video_reg <= 1'b0;
			dim_reg <= 1'b0;
		end else begin
			video_reg <= dotNext;
			dim_reg <= cellVis_reg && cellAttr_reg.dim;
		end
	end

	// drive pulses, placed to centre the text
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hDrive_reg <= 1'b0;
			vSync_reg <= 1'b0;
		end else begin
			hDrive_reg <= (charCnt_reg >= `CGFM_HS_START) && (charCnt_reg < `CGFM_HS_END);
			vSync_reg <= (lineCnt_reg >= `CGFM_VS_START) && (lineCnt_reg < `CGFM_VS_END);
		end
	end

	// blink oscillator toggles every BLINK_FRAMES frames
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			frameCnt_reg <= 8'h00;
			blinkOsc_reg <= 1'b1;
		end else if (frameEnd) begin
			if (frameCnt_reg >= BLINK_FRAMES - 8'h01) begin
				frameCnt_reg <= 8'h00;
				blinkOsc_reg <= ~blinkOsc_reg;
			end else begin
				frameCnt_reg <= frameCnt_reg + 8'h01;
			end
		end
	end

	// processor access: read data return two cycles after the take
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cpuPend_reg <= 1'b0;
			cpuSel_reg <= 1'b0;
			cpuAck_reg <= 1'b0;
			cpuRdData_reg <= 8'h00;
		end else begin
			cpuPend_reg <= cpuTake;
			if (cpuTake) begin
				cpuSel_reg <= cpuAddr[0];
			end
			cpuAck_reg <= cpuPend_reg;
			if (cpuPend_reg) begin
				cpuRdData_reg <= cpuSel_reg ? oddBus.rdata : evenBus.rdata;
			end
		end
	end

	assign cpuAck = cpuAck_reg;
	assign cpuRdData = cpuRdData_reg;
	assign video = video_reg;
	assign dimOut = dim_reg;
	assign hDrive = hDrive_reg;
	assign vSync = vSync_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_take;
		cpuTake;
	endsequence
	sequence s_answer;
		##2 cpuAck_reg;
	endsequence
	property p_dot_wrap;
		(dotCnt_reg == 4'h9) |=> (dotCnt_reg == 4'h0) ##9 (dotCnt_reg == 4'h9);
	endproperty
	a_dot_wrap: assert property (p_dot_wrap) else $error("dot counter not dividing by ten");
	property p_scan_wrap;
		(lineEnd && !frameEnd && scanCnt_reg == 4'hB) |=> (scanCnt_reg == 4'h0);
	endproperty
	a_scan_wrap: assert property (p_scan_wrap) else $error("scan counter not modulo twelve");
	property p_cpu_phase;
		s_take |-> phase2 ##0 s_answer;
	endproperty
	a_cpu_phase: assert property (p_cpu_phase) else $error("processor access outside phase two");
	property p_fetch_hold;
		fetch |-> !phase2 ##2 (holdEven_reg == $past(evenBus.rdata));
	endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("pair not held after refresh read");
	property p_attr_capture;
		(dotCnt_reg == 4'h3 && busVis_reg && charBus_reg[7] && !frameStart)
			|=> (attr_reg == {$past(charBus_reg[5]), $past(charBus_reg[4]), $past(charBus_reg[3]), $past(charBus_reg[2])});
	endproperty
	a_attr_capture: assert property (p_attr_capture) else $error("modifier word not latched");
	property p_frame_clear;
		frameStart |=> (attr_reg == 4'h0);
	endproperty
	a_frame_clear: assert property (p_frame_clear) else $error("attributes survive frame start");
	property p_blank;
		!cellVis_reg |=> !video_reg;
	endproperty
	a_blank: assert property (p_blank) else $error("video during retrace");
	property p_underscore;
		(cellVis_reg && cellScan12_reg && cellAttr_reg.underscore && !cellAttr_reg.inverse
			&& (!cellAttr_reg.blink || blinkOsc_reg)) |=> video_reg;
	endproperty
	a_underscore: assert property (p_underscore) else $error("underscore scan not forced on");
	property p_bars;
		(cellVis_reg && cellMod_reg && cellAttr_reg == 4'h0 && !cellScan12_reg) |=> (video_reg == $past(barDot));
	endproperty
	a_bars: assert property (p_bars) else $error("modifier cell not showing bars");
	property p_dim;
		(cellVis_reg && cellAttr_reg.dim) |=> dim_reg;
	endproperty
	a_dim: assert property (p_dim) else $error("dim output not asserted");
endmodule
`default_nettype wire

// file: hdl/cgfm_consts.svh
// constants of the character generator and field modifier video block
// assumes one 10 MHz clock that stands for the dot clock; included by bare name
`ifndef CGFM_CONSTS_SVH
`define CGFM_CONSTS_SVH
// clock rate in MHz (one clock is one dot)
`define CGFM_CLK_MHZ 10
// raster geometry
`define CGFM_DOT_LAST 4'h9
`define CGFM_CHAR_LAST 7'h63
`define CGFM_VIS_COLS 7'h50
`define CGFM_SCAN_LAST 4'hB
`define CGFM_LINE_LAST 9'h135
`define CGFM_VIS_LINES 9'h120
`define CGFM_ROW_STEP 11'h050
`define CGFM_HS_START 7'h54
`define CGFM_HS_END 7'h5C
`define CGFM_VS_START 9'h12C
`define CGFM_VS_END 9'h130
// dot slots inside one character cell
`define CGFM_PHASE2_DOT 4'h5
`define CGFM_FETCH_DOT 4'h0
`define CGFM_HOLD_DOT 4'h1
`define CGFM_BUS_DOT 4'h2
`define CGFM_ATTR_DOT 4'h3
`define CGFM_CPU_DOT 4'h5
`define CGFM_CPU_DONE_DOT 4'h6
`define CGFM_LOAD_DOT 4'h9
// two-bar pattern of a modifier cell
`define CGFM_BAR_A 4'h2
`define CGFM_BAR_B 4'h6
// underscore on the twelfth scan (index 11)
`define CGFM_UL_SCAN 4'hB
// display word fields
`define CGFM_FM_BIT 7
`define CGFM_UL_BIT 5
`define CGFM_INV_BIT 4
`define CGFM_DIM_BIT 3
`define CGFM_BLK_BIT 2
// memory sizes
`define CGFM_RAM_CHARS 2048
`define CGFM_SCREEN_CHARS 1920
`define CGFM_SPARE_CHARS 128
`define CGFM_GLYPH_WORDS 2048
// frames per half period of the blink oscillator
`define CGFM_BLINK_FRAMES 8'h1E
`endif

// file: hdl/cgfm_pkg.sv
// types shared by the character generator video block
// assumes nothing of its surroundings
package cgfm_pkg;
	// latched field attributes
	typedef struct packed {
		logic underscore;
		logic inverse;
		logic dim;
		logic blink;
	} cgfm_attr_t;
	// one display memory word
	typedef logic [7:0] cgfm_char_t;
endpackage

// file: hdl/cgfm_mem_if.sv
// interface carrying one memory port between the video block and its memories
// assumes a single clock owned by the user of the interface
`timescale 1ns/10ps
`default_nettype none
interface cgfm_mem_if #(parameter int AW = 10, parameter int DW = 8);
	logic [AW-1:0] addr; // word address
	logic we; // write strobe
	logic [DW-1:0] wdata; // write data
	logic [DW-1:0] rdata; // registered read data
	modport ctrl(output addr, output we, output wdata, input rdata);
	modport mem(input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// file: hdl/cgfm_mem.sv
// small synchronous memory with one port and registered read data
// assumes the controller holds addr one cycle ahead of the data it wants
`timescale 1ns/10ps
`default_nettype none
module cgfm_mem #(parameter int AW = 10, parameter int DW = 8) (
	input wire logic clock,
	cgfm_mem_if.mem port
);
	logic [DW-1:0] store [0:(1<<AW)-1]; // contents, not reset
	logic [DW-1:0] rdata_reg; // read register
	// read before write: in a write cycle the read register takes the old word at that address
	always_ff @(posedge clock) begin
		if (port.we) begin
			store[port.addr] <= port.wdata;
		end
		rdata_reg <= store[port.addr];
	end
	assign port.rdata = rdata_reg;
endmodule
`default_nettype wire

// file: hdl/cgfm_shift.sv
// parallel-load video shift register, most significant bit out first
// assumes load and shift come from the dot counter of the same clock
`timescale 1ns/10ps
`default_nettype none
module cgfm_shift #(parameter int W = 10) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] din,
	output logic dout
);
	logic [W-1:0] sr_reg; // dots still to go out
	// load wins; otherwise one dot leaves each clock and zero fills behind
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sr_reg <= '0;
		end else if (load) begin
			sr_reg <= din;
		end else begin
			sr_reg <= {sr_reg[W-2:0], 1'b0};
		end
	end
	assign dout = sr_reg[W-1];
endmodule
`default_nettype wire

// file: verification/cgfm_crt_model.sv
// monitor input model: records serial video, dim, drive and sync over a window of scan lines
// assumes the raster starts at the first clock after reset is released, 1000 dots to a line
`timescale 1ns/10ps
`default_nettype none
module cgfm_crt_model #(parameter int FIRST = 24, parameter int LINES = 24) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic video,
	input wire logic dimOut,
	input wire logic hDrive,
	input wire logic vSync
);
	int cnt; // dots since reset release
	logic [999:0] cap [0:LINES-1]; // serial video of each recorded line
	int dimCnt [0:LINES-1]; // dim cycles per line
	int hCnt [0:LINES-1]; // drive cycles per line
	logic vSeen; // sync seen inside the window
	// counts start clean so a late line never inherits old samples
	initial begin
		vSeen = 1'b0;
		for (int i = 0; i < LINES; i++) begin
			cap[i] = '0;
			dimCnt[i] = 0;
			hCnt[i] = 0;
		end
	end
	// raster position follows the block's clock
	always @(posedge clock) begin
		if (!rst_n) begin
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// sample mid-cycle, where registered outputs have settled
	always @(negedge clock) begin
		int ln;
		int p;
		ln = cnt / 1000 - FIRST;
		p = cnt % 1000;
		if (rst_n === 1'b1 && ln >= 0 && ln < LINES) begin
			cap[ln][p] = video;
			if (dimOut === 1'b1) begin
				dimCnt[ln] = dimCnt[ln] + 1;
			end
			if (hDrive === 1'b1) begin
				hCnt[ln] = hCnt[ln] + 1;
			end
			if (vSync !== 1'b0) begin
				vSeen = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/cgfm_top_tb.sv
// self-checking bench: loads glyphs, fills two screen rows, checks the dots of 24 scan lines
// assumes the first frame shows location 80*row+col and the blink oscillator starts high
`timescale 1ns/10ps
`default_nettype none
module cgfm_top_tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic cpuReq = 1'b0;
	logic cpuWe = 1'b0;
	logic [10:0] cpuAddr = 11'h000;
	logic [7:0] cpuWrData = 8'h00;
	logic glyphWe = 1'b0;
	logic [10:0] glyphAddr = 11'h000;
	logic [7:0] glyphWrData = 8'h00;
	logic cpuAck, video, dimOut, hDrive, vSync;
	logic [7:0] cpuRdData;
	int failures = 0; // mismatches seen
	int n_tests = 0; // comparisons made
	logic [7:0] dm [160:319]; // expected display words of rows 2 and 3
	logic [6:0] codes [0:3] = '{7'h01, 7'h2A, 7'h55, 7'h7F}; // glyphs loaded, spanning the code range
	cgfm_top #(.BLINK_FRAMES(8'h01)) u_cgfm_top(.clock(clock), .rst_n(rst_n), .topOfPage(11'h000),
		.cpuReq(cpuReq), .cpuWe(cpuWe), .cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .cpuAck(cpuAck),
		.cpuRdData(cpuRdData), .glyphWe(glyphWe), .glyphAddr(glyphAddr), .glyphWrData(glyphWrData),
		.video(video), .dimOut(dimOut), .hDrive(hDrive), .vSync(vSync));
	cgfm_crt_model u_cgfm_crt_model(.clock(clock), .rst_n(rst_n), .video(video), .dimOut(dimOut),
		.hDrive(hDrive), .vSync(vSync));
	// 10 MHz dot clock
	always #50 clock = ~clock;
	// glyph row: bit 7 always set, since the block must ignore it
	function automatic logic [7:0] glyph(input logic [6:0] code, input logic [3:0] scan);
		return {1'b1, code ^ {scan, scan[2:0]}};
	endfunction
	// screen content: modifiers every ten columns, data codes between
	function automatic logic [7:0] word(input int loc);
		int c;
		c = loc % 80;
		if (loc >= 240 && c == 0) return 8'hB4;
		case (c)
			0, 20, 70: return 8'h80;
			10: return 8'hE3; // underscore, reserved bits set
			30: return 8'h90;
			40: return 8'h88;
			50: return 8'h84;
			60: return 8'h98;
			default: return {1'b0, codes[c % 4]};
		endcase
	endfunction
	function automatic logic [999:0] shifted(input logic [999:0] e, input int s);
		return (s >= 0) ? e << s : e >> (-s);
	endfunction
	task automatic check(input logic [999:0] seen, input logic [999:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: %s mismatch", $time, what);
		end
	endtask
	task automatic results();
		if (failures == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one processor access, request held until the acknowledge is seen
	task automatic cpu_acc(input logic we, input logic [10:0] a, input logic [7:0] d, output logic [7:0] rd);
		int n;
		@(negedge clock);
		cpuReq = 1'b1;
		cpuWe = we;
		cpuAddr = a;
		cpuWrData = d;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (cpuAck !== 1'b1 && n < 20);
		rd = cpuRdData;
		cpuReq = 1'b0;
		check(1000'(n >= 2 && n <= 12), 1000'(1), "access latency");
	endtask
	task automatic t_glyph();
		for (int k = 0; k < 4; k++) begin
			for (int s = 0; s < 16; s++) begin
				@(negedge clock);
				glyphWe = 1'b1;
				glyphAddr = {codes[k], 4'(s)};
				glyphWrData = glyph(codes[k], 4'(s));
			end
		end
		@(negedge clock);
		glyphWe = 1'b0;
	endtask
	// fill rows 2 and 3, then read back both banks and the spare area
	task automatic t_memory();
		logic [7:0] rd;
		for (int i = 160; i < 320; i++) begin
			dm[i] = word(i);
			cpu_acc(1'b1, 11'(i), dm[i], rd);
		end
		cpu_acc(1'b1, 11'h7FE, 8'h3C, rd);
		cpu_acc(1'b1, 11'h7FF, 8'hC3, rd);
		cpu_acc(1'b1, 11'h780, 8'h5A, rd);
		cpu_acc(1'b0, 11'h7FE, 8'h00, rd);
		check(1000'(rd), 1000'(8'h3C), "even bank");
		cpu_acc(1'b0, 11'h7FF, 8'h00, rd);
		check(1000'(rd), 1000'(8'hC3), "odd bank");
		cpu_acc(1'b0, 11'h780, 8'h00, rd);
		check(1000'(rd), 1000'(8'h5A), "spare area");
		cpu_acc(1'b0, 11'h0A1, 8'h00, rd);
		check(1000'(rd), 1000'(dm[161]), "screen word");
	endtask
	// rebuild each recorded line from the words and compare it dot for dot
	task automatic t_video();
		logic [999:0] e;
		logic [7:0] w, g;
		logic ul, inv, dim, blk, v, osc;
		int best, nd, sc;
		wait (u_cgfm_crt_model.cnt >= 48010);
		{ul, inv, dim, blk} = 4'h0;
		osc = 1'b1;
		best = 0;
		for (int l = 24; l < 48; l++) begin
			e = '0;
			nd = 0;
			sc = l % 12;
			for (int c = 0; c < 80; c++) begin
				w = dm[(l / 12) * 80 + c];
				g = glyph(w[6:0], 4'(sc));
				if (w[7]) begin
					{ul, inv, dim, blk} = w[5:2];
					g = 8'h11;
				end
				nd += dim ? 10 : 0;
				for (int j = 1; j <= 10; j++) begin
					v = (j <= 7) ? g[7 - j] : 1'b0;
					v = v | (ul && sc == 11);
					v = v & (~blk | osc);
					v = v ^ inv;
					e[(c + 1) * 10 + j] = v;
				end
			end
			if (l == 24) begin
				for (int s = -3; s <= 3; s++) begin
					if (u_cgfm_crt_model.cap[0] === shifted(e, s)) best = s;
				end
			end
			check(u_cgfm_crt_model.cap[l - 24], shifted(e, best), "video line");
			check(1000'(u_cgfm_crt_model.dimCnt[l - 24] >= nd - 10 && u_cgfm_crt_model.dimCnt[l - 24] <= nd + 10),
				1000'(1), "dim span");
			check(1000'(u_cgfm_crt_model.hCnt[l - 24]), 1000'(80), "drive width");
		end
		check(1000'(u_cgfm_crt_model.vSeen), 1000'(0), "sync in window");
	endtask
	// a run needs about 48000 cycles; cut a hang short well past that
	initial begin
		#6000000;
		failures++;
		$display("Error at %0t: watchdog expired", $time);
		results();
	end
	initial begin
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		t_glyph();
		t_memory();
		t_video();
		results();
	end
endmodule
`default_nettype wire
